// ==== hw/xex_defs.svh ====
`ifndef XEX_DEFS_SVH
`define XEX_DEFS_SVH

// opcodes, three octal digits packed into nine bits
`define XEX_OP_XCHG     9'h00B
`define XEX_OP_ECM_RD   9'h00C
`define XEX_OP_ECM_WR   9'h00D
`define XEX_OP_IN_CH    9'h00E
`define XEX_OP_OUT_CH   9'h00F

// register byte offsets on the bus
`define XEX_REG_CTRL    12'h000
`define XEX_REG_EXIT    12'h004
`define XEX_REG_STAT    12'h008
`define XEX_REG_CLK     12'h00C

// control register fields
`define XEX_CTRL_MON    0
`define XEX_CTRL_EXIT   1
`define XEX_CTRL_ECM    2
`define XEX_CTRL_FUNC   3

// reset values
`define XEX_CTRL_RST    4'hC
`define XEX_EXIT_RST    18'h00000

// widths and timing
`define XEX_ECM_AW      21
`define XEX_CLK_W       17
`define XEX_ISSUE_NS    50
`define XEX_CLK_NS      50
`define XEX_ISSUE_CYC   ((`XEX_ISSUE_NS + `XEX_CLK_NS - 1) / `XEX_CLK_NS)

`endif

// ==== hw/xex_pkg.sv ====
package xex_pkg;
  // extended memory reference sequencer, gray along idle-req-wait
  typedef enum logic [1:0] {
    XEX_ECM_IDLE = 2'h0,
    XEX_ECM_REQ  = 2'h1,
    XEX_ECM_WAIT = 2'h3
  } xex_ecm_e;
  typedef logic [17:0] xex_addr_t;
  typedef logic [59:0] xex_word_t;
endpackage

// ==== hw/xex_chan.sv ====
`timescale 1ns/10ps
`include "xex_defs.svh"

module xex_chan
  import xex_pkg::*;
#(
  parameter int BUF_W      = 6,
  parameter int ASM_W      = 2,
  parameter bit HIGH_SPEED = 1'b0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_part_stb,
  input  wire logic             in_record_set,
  input  wire logic             in_rst,
  input  wire logic             out_rst,
  input  wire logic             out_accept,
  output logic [BUF_W-1:0]      in_addr,
  output logic [BUF_W-1:0]      out_addr,
  output logic                  out_record_pulse,
  output logic                  out_word_req,
  output logic                  out_disasm_rst,
  output logic                  irq
);

  typedef struct packed {
    logic [BUF_W-1:0] in_addr;
    logic [ASM_W-1:0] asm_pos;
    logic             rec_flag;
    logic [BUF_W-1:0] out_addr;
    logic             out_rec;
    logic             out_arm;
    logic             out_wreq;
    logic             out_drst;
    logic             irq;
  } xex_chan_s;

  xex_chan_s q;
  xex_chan_s next_q;
  logic [BUF_W-1:0] in_inc;
  logic [BUF_W-1:0] out_inc;

  assign in_inc  = q.in_addr + 1'b1;
  assign out_inc = q.out_addr + 1'b1;

  // channel buffer control; reset strobes ignore parts and accepts, but a record set still lands
  always_comb begin
    next_q          = q;
    next_q.irq      = 1'b0;
    next_q.out_rec  = 1'b0;
    next_q.out_drst = 1'b0;
    if (in_rst) begin
      next_q.in_addr = '0;
      next_q.asm_pos = '0;
    end else if (in_part_stb) begin
      if (q.asm_pos == {ASM_W{1'b1}}) begin
        next_q.asm_pos = '0;
        next_q.in_addr = in_inc;
        // half boundary: midpoint or wrap at the end
        if (in_inc[BUF_W-2:0] == '0) begin
          next_q.irq = 1'b1;
        end
      end else begin
        next_q.asm_pos = q.asm_pos + 1'b1;
      end
    end
    // flag turns into a request and drops; a new set wins
    if (q.rec_flag) begin
      next_q.irq      = 1'b1;
      next_q.rec_flag = 1'b0;
    end
    if (in_record_set) begin
      next_q.rec_flag = 1'b1;
    end
    if (out_rst) begin
      next_q.out_addr = HIGH_SPEED ? BUF_W'(1) : '0;
      next_q.out_rec  = 1'b1;
      next_q.out_arm  = 1'b1;
      next_q.out_wreq = 1'b0;
    end else if (q.out_arm) begin
      // word request follows the record pulse by one cycle
      next_q.out_arm  = 1'b0;
      next_q.out_wreq = 1'b1;
      next_q.out_drst = 1'b1;
    end else if (out_accept && q.out_wreq) begin
      next_q.out_addr = out_inc;
      next_q.out_drst = 1'b1;
      if (out_inc[BUF_W-2:0] == '0) begin
        next_q.irq = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign in_addr          = q.in_addr;
  assign out_addr         = q.out_addr;
  assign out_record_pulse = q.out_rec;
  assign out_word_req     = q.out_wreq;
  assign out_disasm_rst   = q.out_drst;
  assign irq              = q.irq;

endmodule

// ==== hw/xex_exec.sv ====
`timescale 1ns/10ps
`include "xex_defs.svh"

module xex_exec
  import xex_pkg::*;
#(
  parameter int        NCH     = 7,
  parameter int        BUF_W   = 6,
  parameter int        ASM_W   = 2,
  parameter bit [7:0]  HS_MASK = 8'h00
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [11:0]      paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             instr_valid,
  input  wire logic [8:0]       instr_op,
  input  wire logic [2:0]       instr_j,
  input  wire logic [2:0]       instr_k,
  input  wire logic [1:0]       instr_parcel,
  input  wire xex_addr_t        cur_word_addr,
  input  wire xex_word_t        operand_reg_dest,
  input  wire xex_word_t        operand_reg_src,
  input  wire xex_addr_t        index_reg_src,
  output logic                  instr_ready,
  output logic                  illegal_op,
  output logic                  xj_we,
  output logic [2:0]            xj_sel,
  output xex_word_t             xj_data,
  output logic                  bj_we,
  output logic [2:0]            bj_sel,
  output xex_addr_t             bj_data,
  output logic                  xchg_req,
  output xex_addr_t             xchg_addr,
  output xex_addr_t             xchg_pa,
  output logic                  iws_void,
  output logic                  parcel_drop,
  input  wire logic             xchg_done,
  input  wire logic             err_exit_in,
  output logic                  err_xchg_req,
  output logic                  io_int_req,
  input  wire logic             io_int_ack,
  output logic                  ecm_req,
  output logic                  ecm_we,
  output logic [20:0]           ecm_addr,
  output xex_word_t             ecm_wdata,
  input  wire logic             ecm_gnt,
  input  wire logic             ecm_rvalid,
  input  wire xex_word_t        ecm_rdata,
  input  wire logic [NCH:1]     in_part_stb,
  input  wire logic [NCH:1]     in_record_set,
  input  wire logic [NCH:1]     out_accept,
  output logic [NCH:1]          out_record_pulse,
  output logic [NCH:1]          out_word_req,
  output logic [NCH:1]          out_disasm_rst
);

  typedef struct packed {
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [3:0]           ctrl;
    xex_addr_t            normal_exit_address;
    logic [`XEX_CLK_W-1:0] clk_cnt;
    xex_ecm_e             ecm_st;
    logic                 ecm_busy;
    logic                 ecm_req;
    logic                 ecm_we;
    logic [20:0]          ecm_addr;
    xex_word_t            ecm_wdata;
    logic [2:0]           ecm_dst;
    logic                 illegal;
    logic                 xj_we;
    logic [2:0]           xj_sel;
    xex_word_t            xj_data;
    logic                 bj_we;
    logic [2:0]           bj_sel;
    xex_addr_t            bj_data;
    logic                 xchg_req;
    logic                 xchg_active;
    xex_addr_t            xchg_addr;
    xex_addr_t            xchg_pa;
    logic                 iws_void;
    logic                 parcel_drop;
    logic [NCH:1]         int_pend;
    logic                 err_req;
    logic                 io_req;
    logic [NCH:1]         in_rst;
    logic [NCH:1]         out_rst;
  } xex_exec_s;

  xex_exec_s q;
  xex_exec_s next_q;

  logic [NCH:1]       ch_irq;
  logic [BUF_W-1:0]   ch_in_addr  [NCH:1];
  logic [BUF_W-1:0]   ch_out_addr [NCH:1];
  logic               wr_ok;
  logic               dec_go;
  logic               func_ok;
  logic               is_ecm;
  logic [2:0]         ch_sel;
  logic               monitor;
  logic [NCH:1]       pend_set;

  // one channel slice per buffer; channel number zero stays for the counter
  for (genvar i = 1; i <= NCH; i++) begin : g_ch
    xex_chan #(
      .BUF_W      (BUF_W),
      .ASM_W      (ASM_W),
      .HIGH_SPEED (HS_MASK[i])
    ) u_chan (
      .pclk             (pclk),
      .presetn          (presetn),
      .in_part_stb      (in_part_stb[i]),
      .in_record_set    (in_record_set[i]),
      .in_rst           (q.in_rst[i]),
      .out_rst          (q.out_rst[i]),
      .out_accept       (out_accept[i]),
      .in_addr          (ch_in_addr[i]),
      .out_addr         (ch_out_addr[i]),
      .out_record_pulse (out_record_pulse[i]),
      .out_word_req     (out_word_req[i]),
      .out_disasm_rst   (out_disasm_rst[i]),
      .irq              (ch_irq[i])
    );
  end

  // bus strobes: the write lands at the edge that samples pready high
  assign wr_ok   = psel && penable && q.pready && pwrite;
  assign dec_go  = instr_valid;
  assign func_ok = q.ctrl[`XEX_CTRL_FUNC];
  assign monitor = q.ctrl[`XEX_CTRL_MON];
  assign is_ecm  = (instr_op == `XEX_OP_ECM_RD) || (instr_op == `XEX_OP_ECM_WR);
  assign ch_sel  = index_reg_src[2:0];

  // an interrupt cause survives until acknowledged; a new cause beats the ack
  always_comb begin
    pend_set = '0;
    for (int i = 1; i <= NCH; i++) begin
      pend_set[i] = ch_irq[i];
    end
  end

  always_comb begin
    next_q             = q;
    next_q.illegal     = 1'b0;
    next_q.xj_we       = 1'b0;
    next_q.bj_we       = 1'b0;
    next_q.xchg_req    = 1'b0;
    next_q.iws_void    = 1'b0;
    next_q.parcel_drop = 1'b0;
    next_q.in_rst      = '0;
    next_q.out_rst     = '0;
    next_q.pslverr     = 1'b0;
    next_q.clk_cnt     = q.clk_cnt + 1'b1;

    // bus slave, one wait state; unmapped offsets answer with an error
    next_q.pready = psel && penable && !q.pready;
    if (psel && penable && !q.pready) begin
      next_q.prdata = '0;
      case (paddr)
        `XEX_REG_CTRL: next_q.prdata[3:0] = q.ctrl;
        `XEX_REG_EXIT: next_q.prdata[17:0] = q.normal_exit_address;
        `XEX_REG_STAT: begin
          next_q.prdata[0]       = q.ecm_busy;
          next_q.prdata[1]       = q.xchg_active;
          next_q.prdata[NCH+8:9] = q.int_pend;
        end
        `XEX_REG_CLK:  next_q.prdata[16:0] = q.clk_cnt;
        default:       next_q.pslverr = 1'b1;
      endcase
    end
    if (wr_ok) begin
      case (paddr)
        `XEX_REG_CTRL: next_q.ctrl = pwdata[3:0];
        `XEX_REG_EXIT: next_q.normal_exit_address = pwdata[17:0];
        default:       next_q.pslverr = 1'b0;
      endcase
    end

    // instruction decode
    if (dec_go) begin
      case (instr_op)
        `XEX_OP_XCHG: begin
          if (!q.ctrl[`XEX_CTRL_EXIT]) begin
            next_q.xchg_req    = 1'b1;
            next_q.xchg_addr   = q.normal_exit_address;
            next_q.xchg_pa     = cur_word_addr + 18'h00001;
            next_q.parcel_drop = 1'b1;
            next_q.iws_void    = 1'b1;
            next_q.xchg_active = 1'b1;
          end
        end
        `XEX_OP_ECM_RD, `XEX_OP_ECM_WR: begin
          if (!func_ok || !q.ctrl[`XEX_CTRL_ECM]) begin
            next_q.illegal = 1'b1;
          end else if (!q.ecm_busy) begin
            // one reference at a time; a busy issue is held upstream
            next_q.ecm_busy  = 1'b1;
            next_q.ecm_req   = 1'b1;
            next_q.ecm_st    = XEX_ECM_REQ;
            next_q.ecm_addr  = operand_reg_src[20:0];
            next_q.ecm_we    = (instr_op == `XEX_OP_ECM_WR);
            next_q.ecm_wdata = operand_reg_dest;
            next_q.ecm_dst   = instr_j;
          end
        end
        `XEX_OP_IN_CH: begin
          if (!func_ok) begin
            next_q.illegal = 1'b1;
          end else if (instr_j == 3'h0) begin
            if (monitor && ch_sel != 3'h0) begin
              next_q.in_rst[ch_sel] = 1'b1;
            end
          end else begin
            next_q.bj_we  = 1'b1;
            next_q.bj_sel = instr_j;
            if (ch_sel == 3'h0) begin
              next_q.bj_data = {1'b0, q.clk_cnt};
            end else begin
              next_q.bj_data = 18'(ch_in_addr[ch_sel]);
            end
          end
        end
        `XEX_OP_OUT_CH: begin
          if (!func_ok) begin
            next_q.illegal = 1'b1;
          end else if (instr_j == 3'h0) begin
            if (monitor && ch_sel != 3'h0) begin
              next_q.out_rst[ch_sel] = 1'b1;
            end
          end else if (ch_sel != 3'h0) begin
            next_q.bj_we   = 1'b1;
            next_q.bj_sel  = instr_j;
            next_q.bj_data = 18'(ch_out_addr[ch_sel]);
          end
        end
        default: next_q.illegal = 1'b0;
      endcase
    end

    // extended memory reference sequencer
    case (q.ecm_st)
      XEX_ECM_IDLE: next_q.ecm_req = next_q.ecm_req;
      XEX_ECM_REQ: begin
        if (ecm_gnt) begin
          next_q.ecm_req = 1'b0;
          if (q.ecm_we) begin
            // bank operand register took the word: write done
            next_q.ecm_busy = 1'b0;
            next_q.ecm_st   = XEX_ECM_IDLE;
          end else begin
            next_q.ecm_st = XEX_ECM_WAIT;
          end
        end
      end
      XEX_ECM_WAIT: begin
        if (ecm_rvalid) begin
          next_q.xj_we    = 1'b1;
          next_q.xj_sel   = q.ecm_dst;
          next_q.xj_data  = ecm_rdata;
          next_q.ecm_busy = 1'b0;
          next_q.ecm_st   = XEX_ECM_IDLE;
        end
      end
      default: next_q.ecm_st = XEX_ECM_IDLE;
    endcase

    // exchange priority: requests stay low while the exit is running
    if (xchg_done && !next_q.xchg_req) begin // a new exit wins over done
      next_q.xchg_active = 1'b0;
    end
    if (io_int_ack) begin
      next_q.int_pend = '0;
    end
    next_q.int_pend = next_q.int_pend | pend_set;
    next_q.io_req   = (|next_q.int_pend) && !next_q.xchg_active;
    next_q.err_req  = err_exit_in && !next_q.xchg_active;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q                     <= '0;
      q.ctrl                <= `XEX_CTRL_RST;
      q.normal_exit_address <= `XEX_EXIT_RST;
      q.ecm_st              <= XEX_ECM_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // every output straight from the state register
  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign instr_ready  = !q.ecm_busy;
  assign illegal_op   = q.illegal;
  assign xj_we        = q.xj_we;
  assign xj_sel       = q.xj_sel;
  assign xj_data      = q.xj_data;
  assign bj_we        = q.bj_we;
  assign bj_sel       = q.bj_sel;
  assign bj_data      = q.bj_data;
  assign xchg_req     = q.xchg_req;
  assign xchg_addr    = q.xchg_addr;
  assign xchg_pa      = q.xchg_pa;
  assign iws_void     = q.iws_void;
  assign parcel_drop  = q.parcel_drop;
  assign err_xchg_req = q.err_req;
  assign io_int_req   = q.io_req;
  assign ecm_req      = q.ecm_req;
  assign ecm_we       = q.ecm_we;
  assign ecm_addr     = q.ecm_addr;
  assign ecm_wdata    = q.ecm_wdata;

endmodule

// ==== test/xex_ecm_bank.sv ====
`timescale 1ns/10ps

module xex_ecm_bank
  import xex_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  dly,
  input  wire logic        ecm_req,
  input  wire logic        ecm_we,
  input  wire logic [20:0] ecm_addr,
  input  wire xex_word_t   ecm_wdata,
  output logic             ecm_gnt,
  output logic             ecm_rvalid,
  output xex_word_t        ecm_rdata
);
  xex_word_t  mem [16];
  logic [3:0] cnt;
  logic [3:0] ra;
  logic       pend;

  // operand register frees after dly cycles; a read word returns one cycle after the grant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cnt, ra, pend, ecm_gnt, ecm_rvalid} <= '0;
      ecm_rdata <= '0;
    end else begin
      ecm_gnt <= 1'b0;
      ecm_rvalid <= pend;
      pend <= 1'b0;
      ecm_rdata <= pend ? mem[ra] : ~ecm_rdata; // idle data toggles so a stale word never matches
      if (ecm_req && !ecm_gnt) begin
        cnt <= cnt + 4'h1;
        if (cnt >= dly) begin
          cnt <= 4'h0;
          ecm_gnt <= 1'b1;
          pend <= !ecm_we;
          ra <= ecm_addr[3:0];
          if (ecm_we) mem[ecm_addr[3:0]] <= ecm_wdata;
        end
      end
    end
  end
endmodule

// ==== test/xex_exec_chk.sv ====
`timescale 1ns/10ps
`include "xex_defs.svh"

module xex_exec_chk
  import xex_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        instr_valid,
  input wire logic [8:0]  instr_op,
  input wire logic [2:0]  instr_j,
  input wire xex_addr_t   cur_word_addr,
  input wire xex_word_t   operand_reg_dest,
  input wire xex_word_t   operand_reg_src,
  input wire logic        instr_ready,
  input wire logic        illegal_op,
  input wire logic        xj_we,
  input wire xex_word_t   xj_data,
  input wire logic        bj_we,
  input wire logic        xchg_req,
  input wire xex_addr_t   xchg_pa,
  input wire logic        iws_void,
  input wire logic        parcel_drop,
  input wire logic        io_int_req,
  input wire logic        ecm_req,
  input wire logic        ecm_we,
  input wire logic [20:0] ecm_addr,
  input wire xex_word_t   ecm_wdata,
  input wire logic        ecm_gnt,
  input wire logic        ecm_rvalid,
  input wire xex_word_t   ecm_rdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // exchange exit side effects
  a_xchg_voids_stack: assert property (xchg_req |-> iws_void && parcel_drop)
    else $error("exchange exit without stack void or parcel drop");
  a_xchg_next_word: assert property (xchg_req |-> xchg_pa == $past(cur_word_addr) + 18'h1)
    else $error("saved program address is not the next word");
  a_xchg_denies_int: assert property (xchg_req |=> !io_int_req)
    else $error("interrupt request granted over exchange exit");
  // extended memory references
  a_rd_issue: assert property (instr_valid && instr_op == `XEX_OP_ECM_RD && instr_ready |=>
    illegal_op || (ecm_req && !ecm_we && ecm_addr == $past(operand_reg_src[20:0])))
    else $error("read reference not issued with low address bits");
  a_wr_issue: assert property (instr_valid && instr_op == `XEX_OP_ECM_WR && instr_ready |=>
    illegal_op || (ecm_req && ecm_we && ecm_wdata == $past(operand_reg_dest)))
    else $error("write reference not issued with dest word");
  a_busy_one_ref: assert property (ecm_req |-> !instr_ready)
    else $error("second reference allowed while busy");
  a_wr_release: assert property (ecm_req && ecm_we && ecm_gnt |=> !ecm_req && instr_ready)
    else $error("write busy not released after bank took word");
  a_rd_deliver: assert property (ecm_rvalid |=> xj_we && xj_data == $past(ecm_rdata))
    else $error("read word not delivered to dest register");
  // channel status forms
  a_status_j0_nop: assert property (instr_valid && instr_op inside {`XEX_OP_IN_CH,
    `XEX_OP_OUT_CH} && instr_j == 3'h0 |=> !bj_we)
    else $error("status write with zero destination");
  a_status_copy: assert property (instr_valid && instr_op == `XEX_OP_IN_CH &&
    instr_j != 3'h0 |=> bj_we || illegal_op)
    else $error("input status not written to dest");

  c_xchg: cover property (xchg_req);
  c_rd: cover property (ecm_rvalid ##1 xj_we);
  c_status: cover property (bj_we);
endmodule

bind xex_exec xex_exec_chk u_chk (
  .pclk(pclk), .presetn(presetn), .instr_valid(instr_valid), .instr_op(instr_op),
  .instr_j(instr_j), .cur_word_addr(cur_word_addr), .operand_reg_dest(operand_reg_dest),
  .operand_reg_src(operand_reg_src), .instr_ready(instr_ready), .illegal_op(illegal_op),
  .xj_we(xj_we), .xj_data(xj_data), .bj_we(bj_we), .xchg_req(xchg_req), .xchg_pa(xchg_pa),
  .iws_void(iws_void), .parcel_drop(parcel_drop), .io_int_req(io_int_req),
  .ecm_req(ecm_req), .ecm_we(ecm_we), .ecm_addr(ecm_addr), .ecm_wdata(ecm_wdata),
  .ecm_gnt(ecm_gnt), .ecm_rvalid(ecm_rvalid), .ecm_rdata(ecm_rdata)
);

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`include "xex_defs.svh"

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
`define WAITF(c) for (int i = 0; !(c); i++) begin if (i > 99) begin n_mismatch++; \
  complete_run; end @(posedge pclk); #1; end

module tb_top
  import xex_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, er, instr_valid = 1'b0, instr_ready, illegal_op;
  logic [8:0]  instr_op = '0;
  logic [2:0]  instr_j = '0, instr_k = '0, xj_sel, bj_sel;
  xex_addr_t   cur_word_addr = '0, index_reg_src = '0, bj_data, xchg_addr, xchg_pa, b1;
  xex_word_t   operand_reg_dest = '0, operand_reg_src = '0, xj_data, ecm_wdata, ecm_rdata;
  logic        xj_we, bj_we, xchg_req, iws_void, parcel_drop, err_xchg_req, io_int_req;
  logic        xchg_done = 1'b0, err_exit_in = 1'b0, io_int_ack = 1'b0;
  logic        ecm_req, ecm_we, ecm_gnt, ecm_rvalid;
  logic [20:0] ecm_addr;
  logic [3:0]  dly = '0;
  logic [7:1]  in_part_stb = '0, in_record_set = '0, out_accept = '0;
  logic [7:1]  out_record_pulse, out_word_req, out_disasm_rst;
  int          n_mismatch = 0, tests_run = 0;

  // channel 3 is the only high-speed output
  xex_exec #(.HS_MASK(8'h08)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_j(instr_j), .instr_k(instr_k),
    .instr_parcel(2'h0), .cur_word_addr(cur_word_addr), .operand_reg_dest(operand_reg_dest),
    .operand_reg_src(operand_reg_src), .index_reg_src(index_reg_src),
    .instr_ready(instr_ready), .illegal_op(illegal_op), .xj_we(xj_we), .xj_sel(xj_sel),
    .xj_data(xj_data), .bj_we(bj_we), .bj_sel(bj_sel), .bj_data(bj_data),
    .xchg_req(xchg_req), .xchg_addr(xchg_addr), .xchg_pa(xchg_pa), .iws_void(iws_void),
    .parcel_drop(parcel_drop), .xchg_done(xchg_done), .err_exit_in(err_exit_in),
    .err_xchg_req(err_xchg_req), .io_int_req(io_int_req), .io_int_ack(io_int_ack),
    .ecm_req(ecm_req), .ecm_we(ecm_we), .ecm_addr(ecm_addr), .ecm_wdata(ecm_wdata),
    .ecm_gnt(ecm_gnt), .ecm_rvalid(ecm_rvalid), .ecm_rdata(ecm_rdata),
    .in_part_stb(in_part_stb), .in_record_set(in_record_set), .out_accept(out_accept),
    .out_record_pulse(out_record_pulse), .out_word_req(out_word_req),
    .out_disasm_rst(out_disasm_rst)
  );

  xex_ecm_bank bank (
    .pclk(pclk), .presetn(presetn), .dly(dly), .ecm_req(ecm_req), .ecm_we(ecm_we),
    .ecm_addr(ecm_addr), .ecm_wdata(ecm_wdata), .ecm_gnt(ecm_gnt),
    .ecm_rvalid(ecm_rvalid), .ecm_rdata(ecm_rdata)
  );

  // 20 MHz
  always #25 pclk = ~pclk;

  task automatic complete_run;
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // apb master: holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      if (++i > 20) begin n_mismatch++; complete_run; end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one instruction for one cycle; returns when its registered answer is visible
  task automatic op(input logic [8:0] o, input logic [2:0] j, input xex_addr_t bk);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_op <= o;
    instr_j <= j;
    instr_k <= bk[2:0];
    index_reg_src <= bk;
    @(posedge pclk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // one assembly part into input channel 1
  task automatic part;
    @(posedge pclk) in_part_stb[1] <= 1'b1;
    @(posedge pclk) in_part_stb[1] <= 1'b0;
  endtask

  task automatic int_ack;
    @(posedge pclk) io_int_ack <= 1'b1;
    @(posedge pclk) io_int_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped offset
    apb(1'b0, `XEX_REG_CTRL, '0);
    `CHK(rd[3:0], `XEX_CTRL_RST);
    apb(1'b0, `XEX_REG_EXIT, '0);
    `CHK(rd[17:0], `XEX_EXIT_RST);
    apb(1'b0, 12'h010, '0);
    `CHK({er, rd}, {1'b1, 32'h0});
    apb(1'b1, `XEX_REG_EXIT, 32'h0002_A5C3);
    apb(1'b1, `XEX_REG_CTRL, 32'h0000_000D);
    // exchange exit while an error exit is already asking
    @(posedge pclk);
    cur_word_addr <= 18'h0_1234;
    err_exit_in <= 1'b1;
    op(`XEX_OP_XCHG, 3'h5, 18'h3);
    `CHK({xchg_req, iws_void, parcel_drop}, 3'h7);
    `CHK(xchg_addr, 18'h2_A5C3);
    `CHK(xchg_pa, 18'h0_1235);
    @(posedge pclk);
    #1;
    `CHK(err_xchg_req, 1'b0);
    @(posedge pclk) xchg_done <= 1'b1;
    @(posedge pclk) xchg_done <= 1'b0;
    `WAITF(err_xchg_req === 1'b1);
    `CHK(err_xchg_req, 1'b1);
    @(posedge pclk) err_exit_in <= 1'b0;
    // write with a slow bank, then read the word back; high address bits are junk
    dly <= 4'h3;
    operand_reg_dest <= 60'hABC_DEF0_1234_5678;
    operand_reg_src <= 60'hFFF_FFFF_FFE0_0005;
    op(`XEX_OP_ECM_WR, 3'h2, '0);
    `CHK({ecm_req, ecm_we, instr_ready, ecm_addr}, {3'h6, 21'h5});
    `WAITF(instr_ready === 1'b1);
    `CHK(ecm_req, 1'b0);
    @(posedge pclk) dly <= 4'h0;
    operand_reg_dest <= '0;
    op(`XEX_OP_ECM_RD, 3'h4, '0);
    `CHK(instr_ready, 1'b0);
    `WAITF(xj_we === 1'b1);
    `CHK({xj_sel, xj_data}, {3'h4, 60'hABC_DEF0_1234_5678});
    // clock period counter, two reads two cycles apart
    op(`XEX_OP_IN_CH, 3'h1, '0);
    b1 = bj_data;
    op(`XEX_OP_IN_CH, 3'h1, '0);
    `CHK(17'(bj_data - b1), 17'h2);
    // seven parts: one word plus three left in assembly
    repeat (7) part();
    op(`XEX_OP_IN_CH, 3'h2, 18'h1);
    `CHK({bj_we, bj_sel, bj_data}, {4'hA, 18'h1});
    op(`XEX_OP_IN_CH, 3'h0, 18'h1);
    `CHK(bj_we, 1'b0);
    part();
    op(`XEX_OP_IN_CH, 3'h2, 18'h1);
    `CHK(bj_data, 18'h0);
    // fill to the buffer midpoint
    repeat (127) part();
    `WAITF(io_int_req === 1'b1);
    `CHK(io_int_req, 1'b1);
    int_ack();
    `CHK(io_int_req, 1'b0);
    @(posedge pclk) in_record_set[1] <= 1'b1;
    @(posedge pclk) in_record_set[1] <= 1'b0;
    `WAITF(io_int_req === 1'b1);
    `CHK(io_int_req, 1'b1);
    int_ack();
    `CHK(io_int_req, 1'b0);
    // monitor answers over the output channel before the next record starts
    op(`XEX_OP_OUT_CH, 3'h0, 18'h1);
    // output reset: record pulse, then word request
    op(`XEX_OP_OUT_CH, 3'h0, 18'h2);
    @(posedge pclk);
    #1;
    `CHK(out_record_pulse[2], 1'b1);
    @(posedge pclk);
    #1;
    `CHK(out_word_req[2], 1'b1);
    `CHK(out_disasm_rst[2], 1'b1);
    op(`XEX_OP_OUT_CH, 3'h1, 18'h2);
    `CHK(bj_data, 18'h0);
    @(posedge pclk) out_accept[2] <= 1'b1;
    @(posedge pclk) out_accept[2] <= 1'b0;
    op(`XEX_OP_OUT_CH, 3'h1, 18'h2);
    `CHK(bj_data, 18'h1);
    op(`XEX_OP_OUT_CH, 3'h0, 18'h3);
    op(`XEX_OP_OUT_CH, 3'h1, 18'h3);
    `CHK(bj_data, 18'h1);
    // without monitor mode the reset is ignored
    apb(1'b1, `XEX_REG_CTRL, 32'h0000_000C);
    op(`XEX_OP_IN_CH, 3'h0, 18'h1);
    op(`XEX_OP_IN_CH, 3'h1, 18'h1);
    `CHK(bj_data, 18'h20);
    // exit mode set: the normal exit form does nothing
    apb(1'b1, `XEX_REG_CTRL, 32'h0000_000E);
    op(`XEX_OP_XCHG, 3'h0, '0);
    `CHK(xchg_req, 1'b0);
    // functions absent, then only the extended memory option absent
    apb(1'b1, `XEX_REG_CTRL, 32'h0000_0005);
    for (logic [8:0] o = `XEX_OP_ECM_RD; o <= `XEX_OP_OUT_CH; o++) begin
      op(o, 3'h1, 18'h1);
      `CHK(illegal_op, 1'b1);
    end
    apb(1'b1, `XEX_REG_CTRL, 32'h0000_0009);
    for (logic [8:0] o = `XEX_OP_ECM_RD; o <= `XEX_OP_OUT_CH; o++) begin
      op(o, 3'h1, 18'h1);
      `CHK(illegal_op, o < `XEX_OP_IN_CH);
    end
    complete_run;
  end
endmodule
